// ---- verilog/sbmd_pkg.sv ----
/*
  Package for the system bus matrix and address decoder: address windows,
  slave and region codes, transfer codes and reset values.
  Assumes AHB-style masters and slaves on one clock.
*/
// What this block does
// - round-robin between processor and DMA masters
// - two master ports, three slave ports
// - AHB peripherals reachable by both masters
// - bridge fully synchronous, no domain crossing
// - narrow APB writes replicated across 32 bits
// - little-endian byte lanes
// - one linear 32-bit address space
// - eight 512 MB blocks from top bits
// - unassigned ranges select no slave
// - reset gates all peripheral clocks except memories
// - ports A, B, C in 1 KB slots
// - ports D, F decoded, rest reserved
// - core-internal range kept off system slaves
// - DMA, request mux, clock controller slots
// - interrupt controller, flash regs, CRC slots
// - three timer slots on APB
// - serial port and debug slots on APB
// - boot alias at bottom of map
// - SRAM window, reserved above it
// - main Flash window
// - option bytes and system memory windows
package sbmd_pkg;

  // ---------------------------------------------------------------
  // slave selection codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SBMD_SL_FLASH = 2'h0,
    SBMD_SL_SRAM = 2'h1,
    SBMD_SL_BRIDGE = 2'h2,
    SBMD_SL_NONE = 2'h3
  } sbmd_slave_e;

  // fine-grained region index, one-hot select bus position
  localparam int SBMD_NREG = 22;
  localparam int RG_BOOT = 0;
  localparam int RG_FLASH = 1;
  localparam int RG_SYSMEM = 2;
  localparam int RG_OPTB = 3;
  localparam int RG_SRAM = 4;
  localparam int RG_SER1 = 5;
  localparam int RG_TIMA = 6;
  localparam int RG_TIMB = 7;
  localparam int RG_TIMC = 8;
  localparam int RG_DBG = 9;
  localparam int RG_DMA = 10;
  localparam int RG_DMUX = 11;
  localparam int RG_RCC = 12;
  localparam int RG_EXTERNAL_INTERRUPT_CONTROLLER = 13;
  localparam int RG_FREG = 14;
  localparam int RG_CRC = 15;
  localparam int RG_PA = 16;
  localparam int RG_PB = 17;
  localparam int RG_PC = 18;
  localparam int RG_PD = 19;
  localparam int RG_PF = 20;
  localparam int RG_CORE = 21;

  // ---------------------------------------------------------------
  // address windows, inclusive bounds
  // ---------------------------------------------------------------
  localparam logic [31:0] REG_LO [SBMD_NREG] = '{
    32'h0000_0000, 32'h0800_0000, 32'h1FFF_0000, 32'h1FFF_7800,
    32'h2000_0000, 32'h4001_3800, 32'h4001_4000, 32'h4001_4400,
    32'h4001_4800, 32'h4001_5800, 32'h4002_0000, 32'h4002_0800,
    32'h4002_1000, 32'h4002_1800, 32'h4002_2000, 32'h4002_3000,
    32'h5000_0000, 32'h5000_0400, 32'h5000_0800, 32'h5000_0C00,
    32'h5000_1400, 32'hE000_0000};
  localparam logic [31:0] REG_HI [SBMD_NREG] = '{
    32'h0001_FFFF, 32'h0801_FFFF, 32'h1FFF_77FF, 32'h1FFF_7FFF,
    32'h2000_8FFF, 32'h4001_3BFF, 32'h4001_43FF, 32'h4001_47FF,
    32'h4001_4BFF, 32'h4001_5BFF, 32'h4002_03FF, 32'h4002_0BFF,
    32'h4002_13FF, 32'h4002_1BFF, 32'h4002_23FF, 32'h4002_33FF,
    32'h5000_03FF, 32'h5000_07FF, 32'h5000_0BFF, 32'h5000_0FFF,
    32'h5000_17FF, 32'hE00F_FFFF};

  // ---------------------------------------------------------------
  // transfer codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [1:0] BOOT_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SYSMEM = 2'h1;
  localparam logic [1:0] BOOT_SRAM = 2'h2;
  localparam logic [2:0] BLOCK_MSB = 3'h7;
  localparam int BLOCK_LSB = 29;
  localparam int PCLK_W = 16;
  localparam logic [PCLK_W-1:0] PCLK_RST = 16'h0000;

endpackage : sbmd_pkg

// ---- verilog/sbmd_matrix.sv ----
/*
  System bus matrix with address decoder and synchronous APB bridge.
  Two masters share three slaves with round-robin grant; one transfer is
  in flight at a time. Assumes one clock, AHB-style handshakes and that
  masters hold request and address until done is seen.
*/
`timescale 1ns/1ps
module sbmd_matrix #(
  parameter int DW = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  // master requests: index 0 processor, 1 DMA; three slaves below
  input wire logic [1:0] m_req,
  input wire logic [1:0] m_write,
  input wire logic [63:0] m_addr,
  input wire logic [5:0] m_size,
  input wire logic [63:0] m_wdata,
  output logic [1:0] m_done,
  output logic [1:0] m_err,
  output logic [63:0] m_rdata,
  // boot selection and peripheral clock enables
  input wire logic [1:0] boot_sel,
  input wire logic pclk_we,
  input wire logic [15:0] pclk_wdata,
  output logic [15:0] pclk_en_q,
  // memory slaves (flash, sram)
  output logic [1:0] mem_sel_q,
  output logic mem_write_q,
  output logic [31:0] mem_addr_q,
  output logic [2:0] mem_size_q,
  output logic [31:0] mem_wdata_q,
  input wire logic [1:0] mem_ready,
  input wire logic [63:0] mem_rdata,
  // apb side of the bridge
  output logic psel_q,
  output logic penable_q,
  output logic pwrite_q,
  output logic [31:0] paddr_q,
  output logic [31:0] pwdata_q,
  output logic [21:0] pregion_q,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // core-internal peripheral strobe
  output logic core_sel_q
);

  // ---------------------------------------------------------------
  // arbitration state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SBMD_IDLE = 2'h0,
    SBMD_MEM = 2'h1,
    SBMD_APB_SET = 2'h2,
    SBMD_APB_EN = 2'h3
  } sbmd_state_e;

  localparam int SBMD_NREG = sbmd_pkg::SBMD_NREG;

  sbmd_state_e state_q;
  logic last_q;
  logic owner_q;
  logic pick;
  logic [31:0] addr_sel;
  logic [SBMD_NREG-1:0] hit;
  sbmd_pkg::sbmd_slave_e slave;
  logic [31:0] wlane;
  logic [1:0] done_d;
  logic [1:0] err_d;
  logic [31:0] rd_d;

  // round-robin pick: the master not served last wins a contest
  always_comb begin
    pick = 1'b0;
    if (m_req == 2'h3) begin
      pick = ~last_q;
    end else if (m_req[1]) begin
      pick = 1'b1;
    end
  end

  assign addr_sel = pick ? m_addr[63:32] : m_addr[31:0];

  // one comparator pair per region, one flat 32-bit map
  generate
    for (genvar i = 0; i < SBMD_NREG; i++) begin : g_dec
      assign hit[i] = (addr_sel >= sbmd_pkg::REG_LO[i]) &&
                      (addr_sel <= sbmd_pkg::REG_HI[i]);
    end
  endgenerate

  // region to slave; top three bits pick the 512 MB block first
  always_comb begin
    slave = sbmd_pkg::SBMD_SL_NONE;
    unique case (addr_sel[31:sbmd_pkg::BLOCK_LSB])
      3'h0: begin
        if (hit[sbmd_pkg::RG_FLASH] || hit[sbmd_pkg::RG_SYSMEM] ||
            hit[sbmd_pkg::RG_OPTB]) begin
          slave = sbmd_pkg::SBMD_SL_FLASH;
        end else if (hit[sbmd_pkg::RG_BOOT]) begin
          slave = (boot_sel == sbmd_pkg::BOOT_SRAM) ?
                  sbmd_pkg::SBMD_SL_SRAM : sbmd_pkg::SBMD_SL_FLASH;
        end
      end
      3'h1: begin
        if (hit[sbmd_pkg::RG_SRAM]) begin
          slave = sbmd_pkg::SBMD_SL_SRAM;
        end
      end
      3'h2: begin
        // AHB and APB peripherals plus ports, all on the bridge path
        if (|hit[sbmd_pkg::RG_PF:sbmd_pkg::RG_SER1]) begin
          slave = sbmd_pkg::SBMD_SL_BRIDGE;
        end
      end
      default: begin
        slave = sbmd_pkg::SBMD_SL_NONE;
      end
    endcase
  end

  // replicate narrow write data over all byte lanes
  always_comb begin
    wlane = pick ? m_wdata[63:32] : m_wdata[31:0];
    if (m_size[pick*3 +: 3] == sbmd_pkg::HSIZE_BYTE) begin
      wlane = {4{wlane[7:0]}};
    end else if (m_size[pick*3 +: 3] == sbmd_pkg::HSIZE_HALF) begin
      wlane = {2{wlane[15:0]}};
    end
  end

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  // grant held until the slave completes; only then re-arbitrate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SBMD_IDLE;
      owner_q <= 1'b0;
      last_q <= 1'b1;
    end else begin
      unique case (state_q)
        SBMD_IDLE: begin
          if (|m_req && !(|m_done) && !(|m_err)) begin
            owner_q <= pick;
            if (slave == sbmd_pkg::SBMD_SL_BRIDGE) begin
              state_q <= SBMD_APB_SET;
            end else if (slave != sbmd_pkg::SBMD_SL_NONE) begin
              state_q <= SBMD_MEM;
            end else begin
              last_q <= pick;
            end
          end
        end
        SBMD_MEM: begin
          if (mem_ready[mem_sel_q == 2'h2]) begin
            state_q <= SBMD_IDLE;
            last_q <= owner_q;
          end
        end
        SBMD_APB_SET: begin
          state_q <= SBMD_APB_EN;
        end
        SBMD_APB_EN: begin
          if (pready) begin
            state_q <= SBMD_IDLE;
            last_q <= owner_q;
          end
        end
      endcase
    end
  end

  // slave-side address and data captured at grant
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_sel_q <= 2'h0;
      mem_write_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_size_q <= 3'h0;
      mem_wdata_q <= 32'h0000_0000;
      psel_q <= 1'b0;
      penable_q <= 1'b0;
      pwrite_q <= 1'b0;
      paddr_q <= 32'h0000_0000;
      pwdata_q <= 32'h0000_0000;
      pregion_q <= 22'h00_0000;
      core_sel_q <= 1'b0;
    end else begin
      core_sel_q <= 1'b0;
      if (state_q == SBMD_IDLE && |m_req && !(|m_done) && !(|m_err)) begin
        core_sel_q <= hit[sbmd_pkg::RG_CORE];
        mem_write_q <= m_write[pick];
        mem_addr_q <= addr_sel;
        mem_size_q <= m_size[pick*3 +: 3];
        mem_wdata_q <= pick ? m_wdata[63:32] : m_wdata[31:0];
        if (slave == sbmd_pkg::SBMD_SL_FLASH) begin
          mem_sel_q <= 2'h1;
        end else if (slave == sbmd_pkg::SBMD_SL_SRAM) begin
          mem_sel_q <= 2'h2;
        end
        if (slave == sbmd_pkg::SBMD_SL_BRIDGE) begin
          psel_q <= 1'b1;
          pwrite_q <= m_write[pick];
          paddr_q <= {addr_sel[31:2], 2'h0};
          pwdata_q <= wlane;
          pregion_q <= hit;
        end
      end else if (state_q == SBMD_MEM && mem_ready[mem_sel_q == 2'h2]) begin
        mem_sel_q <= 2'h0;
      end else if (state_q == SBMD_APB_SET) begin
        penable_q <= 1'b1;
      end else if (state_q == SBMD_APB_EN && pready) begin
        psel_q <= 1'b0;
        penable_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // answers to the masters
  // ---------------------------------------------------------------
  // done and error pulse one cycle to the owning master
  always_comb begin
    done_d = 2'h0;
    err_d = 2'h0;
    rd_d = 32'h0000_0000;
    if (state_q == SBMD_MEM && mem_ready[mem_sel_q == 2'h2]) begin
      done_d[owner_q] = 1'b1;
      rd_d = (mem_sel_q == 2'h2) ? mem_rdata[63:32] : mem_rdata[31:0];
    end else if (state_q == SBMD_APB_EN && pready) begin
      done_d[owner_q] = 1'b1;
      rd_d = prdata;
    end else if (state_q == SBMD_IDLE && |m_req && !(|m_done) &&
                 !(|m_err) && slave == sbmd_pkg::SBMD_SL_NONE) begin
      err_d[pick] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      m_done <= 2'h0;
      m_err <= 2'h0;
      m_rdata <= 64'h0;
    end else begin
      m_done <= done_d;
      m_err <= err_d;
      if (done_d[0]) begin
        m_rdata[31:0] <= rd_d;
      end
      if (done_d[1]) begin
        m_rdata[63:32] <= rd_d;
      end
    end
  end

  // peripheral clock gates: all off after reset, memories not gated here
  // software must set a bit before touching that peripheral
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pclk_en_q <= sbmd_pkg::PCLK_RST;
    end else if (pclk_we) begin
      pclk_en_q <= pclk_wdata;
    end
  end

endmodule // sbmd_matrix

// ---- sim/sbmd_matrix_checker.sv ----
/*
  Port checker for sbmd_matrix, bound to it at the foot of this file.
  Assumes one clock domain with the asynchronous reset arst_n.
*/
`timescale 1ns/1ps
module sbmd_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [1:0] m_done,
  input wire logic [1:0] m_err,
  input wire logic [15:0] pclk_en_q,
  input wire logic [1:0] mem_sel_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic [1:0] mem_ready,
  input wire logic psel_q,
  input wire logic penable_q,
  input wire logic [31:0] paddr_q,
  input wire logic pready,
  input wire logic core_sel_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // answers, holds and decode side effects
  // ---------------------------------------------------------------
  a_clk_reset: assert property (!$past(arst_n) |-> pclk_en_q == 16'h0000)
    else $error("clock enables not cleared by reset");
  a_err_clean: assert property (|m_err |-> !psel_q && mem_sel_q == 2'h0)
    else $error("error answer with a slave selected");
  a_one_answer: assert property ($onehot0({m_done, m_err}))
    else $error("two answers in one cycle");
  a_ans_pulse: assert property (|{m_done, m_err} |=> !(|{m_done, m_err}))
    else $error("answer longer than one cycle");
  a_apb_phase: assert property (psel_q && !penable_q |=>
    psel_q && penable_q && $stable(paddr_q))
    else $error("apb setup not followed by enable");
  a_apb_wait: assert property (psel_q && penable_q && !pready |=>
    psel_q && penable_q && $stable(paddr_q))
    else $error("apb transfer dropped before ready");
  a_apb_done: assert property (psel_q && penable_q && pready |=>
    m_done != 2'h0 && !psel_q)
    else $error("no done one cycle after apb ready");
  a_mem_wait: assert property (mem_sel_q != 2'h0 &&
    (mem_sel_q & mem_ready) == 2'h0 |=> $stable({mem_sel_q, mem_addr_q}))
    else $error("memory request changed before ready");
  a_mem_done: assert property ((mem_sel_q & mem_ready) != 2'h0 |=>
    m_done != 2'h0 && mem_sel_q == 2'h0)
    else $error("no done one cycle after memory ready");
  a_word_addr: assert property (psel_q |-> paddr_q[1:0] == 2'h0)
    else $error("apb address not word aligned");
  a_core_pulse: assert property (core_sel_q |->
    !psel_q && mem_sel_q == 2'h0 ##1 !core_sel_q)
    else $error("core strobe wrong");
endmodule // sbmd_checker

bind sbmd_matrix sbmd_checker u_chk (.core_clk, .arst_n, .m_done, .m_err,
  .pclk_en_q, .mem_sel_q, .mem_addr_q, .mem_ready, .psel_q, .penable_q,
  .paddr_q, .pready, .core_sel_q);

// ---- sim/sbmd_slave_model.sv ----
/*
  Far-side model: flash, sram and apb peripherals with set wait states.
  Assumes the matrix keeps at most one transfer open at a time.
*/
`timescale 1ns/1ps
module sbmd_slave_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] wait_n,
  input wire logic [1:0] mem_sel_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic psel_q,
  input wire logic penable_q,
  input wire logic [31:0] paddr_q,
  output logic [1:0] mem_ready,
  output logic [63:0] mem_rdata,
  output logic pready,
  output logic [31:0] prdata
);
  logic [3:0] cnt_q;
  logic rdy_q;
  logic busy;
  logic [31:0] val;
  // one counter serves both paths, only one transfer is ever open
  assign busy = mem_sel_q != 2'h0 || (psel_q && penable_q);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      rdy_q <= 1'b0;
    end else if (busy && !rdy_q) begin
      cnt_q <= cnt_q + 4'h1;
      rdy_q <= cnt_q >= wait_n;
    end else begin
      cnt_q <= 4'h0;
      rdy_q <= 1'b0;
    end
  end
  // idle data lines show the inverse so a stale value never matches
  assign val = (mem_sel_q != 2'h0 ? mem_addr_q : paddr_q) ^ 32'h5A5A_0000;
  assign mem_ready = rdy_q ? {mem_sel_q == 2'h2, mem_sel_q == 2'h1} : 2'h0;
  assign pready = rdy_q && psel_q;
  assign mem_rdata = rdy_q ? {val, val} : ~{val, val};
  assign prdata = rdy_q ? val : ~val;
endmodule // sbmd_slave_model

// ---- sim/sbmd_matrix_tb.sv ----
/*
  Self-checking bench for sbmd_matrix, one task per scenario.
  Assumes the slave model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module sbmd_matrix_tb;
  localparam logic [31:0] KEY = 32'h5A5A_0000;
  // code F1 flash, F2 sram, EE reserved, EC core, else apb region index
  localparam logic [39:0] MAP [32] = '{
    40'hF1_0800_0000, 40'hF1_0801_FFFC, 40'hEE_0802_0000, 40'hEE_4002_0400,
    40'hF2_2000_0000, 40'hF2_2000_8FFC, 40'hEE_2000_9000, 40'h05_4001_3800,
    40'hEE_4001_3C00, 40'h06_4001_4000, 40'h07_4001_4400, 40'h08_4001_4800,
    40'h09_4001_5800, 40'hEE_4001_5C00, 40'h0A_4002_0000, 40'h0B_4002_0800,
    40'h0C_4002_1000, 40'h0D_4002_1800, 40'h0E_4002_2000, 40'h0F_4002_3000,
    40'hEE_4002_3400, 40'h10_5000_0000, 40'h11_5000_0400, 40'h12_5000_0800,
    40'h13_5000_0C00, 40'hEE_5000_1000, 40'h14_5000_1400, 40'hEE_5000_1800,
    40'hEC_E000_0000, 40'hEC_E00F_FFFC, 40'hEE_E010_0000, 40'hEE_6000_0000};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pclk_we = 1'b0;
  logic [1:0] m_req = 2'h0, m_write = 2'h0, boot_sel = 2'h0;
  logic [5:0] m_size = 6'h12;
  logic [63:0] m_addr = 64'h0, m_wdata = 64'h0;
  logic [15:0] pclk_wdata = 16'h0000;
  logic [3:0] wait_n = 4'h2;
  logic [1:0] m_done, m_err, mem_sel_q, mem_ready, s_mem;
  logic [63:0] m_rdata, mem_rdata;
  logic [15:0] pclk_en_q;
  logic mem_write_q, psel_q, penable_q, pwrite_q, pready, core_sel_q;
  logic [31:0] mem_addr_q, mem_wdata_q, paddr_q, pwdata_q, prdata;
  logic [31:0] r_rdata, s_paddr, s_pwdata;
  logic [2:0] mem_size_q;
  logic [21:0] pregion_q, s_reg;
  logic r_done, r_err, s_psel, s_core;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  always #2.5 core_clk = ~core_clk;

  sbmd_matrix uut (.core_clk, .arst_n, .m_req, .m_write, .m_addr, .m_size,
    .m_wdata, .m_done, .m_err, .m_rdata, .boot_sel, .pclk_we, .pclk_wdata,
    .pclk_en_q, .mem_sel_q, .mem_write_q, .mem_addr_q, .mem_size_q,
    .mem_wdata_q, .mem_ready, .mem_rdata, .psel_q, .penable_q, .pwrite_q,
    .paddr_q, .pwdata_q, .pregion_q, .pready, .prdata, .core_sel_q);
  sbmd_slave_model slv (.core_clk, .arst_n, .wait_n, .mem_sel_q, .mem_addr_q,
    .psel_q, .penable_q, .paddr_q, .mem_ready, .mem_rdata, .pready, .prdata);

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      close_out();
    end
  end

  // one transfer, held until its answer, noting what the slaves saw
  task automatic xfer(input int m, input logic wr, input logic [31:0] a,
                      input logic [2:0] sz, input logic [31:0] wd);
    @(posedge core_clk);
    m_req[m] <= 1'b1;
    m_write[m] <= wr;
    m_addr[m*32+:32] <= a;
    m_size[m*3+:3] <= sz;
    m_wdata[m*32+:32] <= wd;
    {r_done, r_err, s_psel, s_core, s_mem, s_reg} = '0;
    for (int n = 0; n < 40 && !(r_done || r_err); n++) begin
      @(posedge core_clk);
      s_mem |= mem_sel_q;
      s_psel |= psel_q;
      s_core |= core_sel_q;
      if (psel_q) s_reg |= pregion_q;
      if (psel_q) {s_paddr, s_pwdata} = {paddr_q, pwdata_q};
      {r_done, r_err, r_rdata} = {m_done[m], m_err[m], m_rdata[m*32+:32]};
    end
    m_req[m] <= 1'b0;
  endtask

  // both masters keep asking for sram; grants must alternate
  task automatic race();
    logic [1:0] got;
    @(posedge core_clk);
    m_addr <= {32'h2000_0040, 32'h2000_0080};
    m_req <= 2'h3;
    for (int k = 0; k < 4; k++) begin
      got = 2'h0;
      for (int n = 0; n < 40 && got == 2'h0; n++) begin
        @(posedge core_clk);
        got = m_done;
      end
      chk(got, k[0] ? 2'h2 : 2'h1);
      chk(got[0] ? m_rdata[31:0] : m_rdata[63:32],
          (got[0] ? 32'h2000_0080 : 32'h2000_0040) ^ KEY);
      m_req <= k == 3 ? 2'h0 : m_req & ~got;
      @(posedge core_clk);
      if (k < 3) m_req <= 2'h3;
    end
  endtask

  // reset leaves clocks off until the master turns them on
  task automatic clocks();
    chk(pclk_en_q, 16'h0000);
    pclk_wdata <= 16'hFFFF;
    pclk_we <= 1'b1;
    @(posedge core_clk);
    pclk_we <= 1'b0;
    @(posedge core_clk);
    chk(pclk_en_q, 16'hFFFF);
  endtask

  // narrow apb writes widen to one aligned word
  task automatic narrow();
    xfer(0, 1'b1, 32'h4001_4000, sbmd_pkg::HSIZE_BYTE, 32'h0000_00AB);
    chk({s_paddr, s_pwdata}, {32'h4001_4000, 32'hABAB_ABAB});
    xfer(1, 1'b1, 32'h4001_4400, sbmd_pkg::HSIZE_HALF, 32'h0000_1234);
    chk({s_paddr, s_pwdata}, {32'h4001_4400, 32'h1234_1234});
    xfer(0, 1'b1, 32'h4001_4803, sbmd_pkg::HSIZE_BYTE, 32'hCDCD_CDCD);
    chk({s_paddr, s_pwdata}, {32'h4001_4800, 32'hCDCD_CDCD});
    chk(pwrite_q, 1'b1);
  endtask

  // address map walk from both masters, reads and writes mixed
  task automatic decode();
    logic [7:0] c;
    logic [31:0] a;
    for (int b = 0; b < 3; b++) begin
      boot_sel <= 2'(b);
      xfer(b % 2, 1'b0, 32'h0000_0100, 3'h2, 32'h0);
      chk(s_mem, b == 2 ? 2'h2 : 2'h1);
    end
    for (int i = 0; i < 32; i++) begin
      {c, a} = MAP[i];
      wait_n <= 4'(i % 3);
      xfer(i % 2, i[1], a, 3'h2, ~a);
      case (c)
        8'hF1, 8'hF2: begin
          chk(s_mem, c[1:0]);
          chk({mem_write_q, mem_wdata_q, mem_size_q}, {i[1], ~a, 3'h2});
        end
        8'hEE: chk({r_err, s_mem, s_psel}, 4'h8);
        8'hEC: chk({r_err, s_core, s_mem, s_psel}, 5'h18);
        default: chk(s_reg, 22'h1 << c);
      endcase
      if (c[7:4] != 4'hE) chk({r_done, r_err}, 2'h2);
      if (c[7:4] != 4'hE && !i[1]) chk(r_rdata, a ^ KEY);
    end
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    race();
    clocks();
    narrow();
    decode();
    close_out();
  end
endmodule // sbmd_matrix_tb
